// ---- core/pcs_defines.svh ----
// Offsets, bit positions and reset values of the port charger status registers
`ifndef PCS_DEFINES_SVH
`define PCS_DEFINES_SVH
// Register offsets
`define PCS_GS_OFF 8'h11
`define PCS_GP_OFF 8'h12
`define PCS_GL_OFF 8'h13
`define PCS_PIN_OFF 8'h14
// General status bit positions
`define PCS_GS_BUDGET 7
`define PCS_GS_CLAMP 4
`define PCS_GS_THERMAL 3
`define PCS_GS_TRICKLE 2
`define PCS_GS_DETACH 1
`define PCS_GS_PLUGIN 0
// Implemented bits and clear-on-read bits of general status
`define PCS_GS_MASK 8'h9F
`define PCS_GS_COR_MASK 8'h8F
// Profile status primary bit positions
`define PCS_GP_NOHS 7
`define PCS_GP_UVLO 4
`define PCS_GP_USER 3
`define PCS_GP_DCP 2
`define PCS_GP_CHP 1
`define PCS_GP_PT 0
// Pin status bit positions
`define PCS_PIN_PWR 6
`define PCS_PIN_MODE_B 5
`define PCS_PIN_MODE_A 4
`define PCS_PIN_EMU 3
`define PCS_PIN_STRAP 2
// Power state codes
`define PCS_PS_SLEEP 2'h0
`define PCS_PS_DETECT 2'h1
// Budget behaviour code that interrupts the host
`define PCS_BEH_INTERRUPT 2'h0
// Reset values
`define PCS_FLAGS_RST 8'h00
`define PCS_PT_ARMED_RST 1'b1
`define PCS_UNMAPPED_DATA 8'h00
`endif

// ---- core/pcs_pkg.sv ----
// Types shared by the port charger status register files
package pcs_pkg;
    typedef logic [7:0] pcs_byte_t;
    typedef logic [1:0] pcs_pstate_t;
    typedef logic [2:0] pcs_mode_t;

    typedef struct packed {
        pcs_byte_t q;
    } pcs_cell_s;

    typedef struct packed {
        logic attach;
        logic alert;
        logic hsw;
        logic trip;
        pcs_byte_t rd_data;
        logic rd_ack;
        logic strap;
        logic strap_done;
        logic pt_armed;
        pcs_mode_t mode_prev;
    } pcs_main_s;
endpackage

// ---- core/pcs_status_regs.sv ----
// Status register group of the port power controller: flags, pins and read port
`timescale 1ns/10ps
`include "pcs_defines.svh"
module pcs_status_regs (
    input wire logic i_core_clk,
    input wire logic i_reset_n,
    input wire logic i_rd_en,
    input wire pcs_pkg::pcs_byte_t i_rd_addr,
    input wire logic i_budget_hit,
    input wire logic i_clamp_active,
    input wire logic i_thermal_event,
    input wire logic i_low_current_event,
    input wire logic i_removal_event,
    input wire logic i_attach_event,
    input wire logic i_vs_below_uvlo,
    input wire logic i_dce_active,
    input wire logic i_profile_applied,
    input wire logic i_profile_handshake_missing_flag,
    input wire logic i_accept_custom,
    input wire logic i_accept_dcp,
    input wire logic i_accept_chp,
    input wire logic [6:0] i_accept_legacy,
    input wire logic i_passthrough_mode,
    input wire logic i_budget_reset_control,
    input wire logic i_budget_enable_control,
    input wire logic [1:0] i_budget_behaviour_select,
    input wire logic i_alert_link,
    input wire logic i_custom_hsw_closed,
    input wire logic i_custom_trip_limit,
    input wire logic i_data_switch_in_dedicated,
    input wire logic i_port_power_enable_pin,
    input wire logic i_port_power_enable_set,
    input wire logic i_mode_input_a_pin,
    input wire logic i_mode_input_a_set,
    input wire logic i_mode_input_b_pin,
    input wire logic i_mode_input_b_set,
    input wire logic i_emulation_enable_pin,
    input wire logic i_emulation_enable_set,
    input wire logic i_sel_strap,
    input wire pcs_pkg::pcs_pstate_t i_power_state_code,
    output pcs_pkg::pcs_byte_t o_rd_data,
    output logic o_rd_ack,
    output logic o_fault_alert,
    output logic o_attach_out,
    output logic o_data_switch_closed,
    output logic o_trip_limit
);
    import pcs_pkg::*;

    pcs_main_s st_r;
    pcs_main_s st_nxt;
    pcs_byte_t gs_q;
    pcs_byte_t gs_set;
    pcs_byte_t gs_clr;
    pcs_byte_t gp_q;
    pcs_byte_t gp_set;
    pcs_byte_t gp_clr;
    pcs_byte_t gl_q;
    pcs_byte_t gl_set;
    pcs_byte_t gl_clr;
    logic pwr_eff;
    logic mode_a_eff;
    logic mode_b_eff;
    logic emu_eff;
    pcs_mode_t mode_now;
    logic mode_chg;
    logic prof_clr;
    logic gs_read;
    logic pt_set;
    logic accept_any;
    logic others_held;
    logic nohs_set;

    // Sleep is never shown, a register access has already woken the part
    function automatic pcs_pstate_t wake_state(input pcs_pstate_t code);
        if (code == `PCS_PS_SLEEP)
            return `PCS_PS_DETECT;
        return code;
    endfunction

    // Switch and limit choice from the accepted profile, highest first
    function automatic logic [1:0] path_select(input pcs_byte_t gp, input pcs_byte_t gl);
        if (gp[`PCS_GP_CHP] || gp[`PCS_GP_PT])
            return 2'h3;
        if (gp[`PCS_GP_DCP])
            return {i_data_switch_in_dedicated, 1'b0};
        if (gp[`PCS_GP_USER])
            return {i_custom_hsw_closed, i_custom_trip_limit};
        if (|gl)
            return {i_data_switch_in_dedicated, i_custom_trip_limit};
        return {1'b0, i_custom_trip_limit};
    endfunction

    // Effective controls: pin state joined with its software set bit
    assign pwr_eff = (st_r.strap ? i_port_power_enable_pin : ~i_port_power_enable_pin)
                     | i_port_power_enable_set;
    assign mode_a_eff = i_mode_input_a_pin | i_mode_input_a_set;
    assign mode_b_eff = i_mode_input_b_pin | i_mode_input_b_set;
    assign emu_eff = i_emulation_enable_pin | i_emulation_enable_set;
    assign mode_now = {mode_b_eff, mode_a_eff, emu_eff};
    assign mode_chg = (mode_now != st_r.mode_prev);

    // Common clear of the accepted-profile flags
    assign prof_clr = ~pwr_eff | mode_chg | i_removal_event;
    assign gs_read = i_rd_en && (i_rd_addr == `PCS_GS_OFF);

    // General status: events set, a read of the register clears all but the clamp flag
    always_comb
    begin
        gs_set = 8'h00;
        gs_set[`PCS_GS_BUDGET] = i_budget_hit;
        gs_set[`PCS_GS_CLAMP] = i_clamp_active;
        gs_set[`PCS_GS_THERMAL] = i_thermal_event;
        gs_set[`PCS_GS_TRICKLE] = i_low_current_event;
        gs_set[`PCS_GS_DETACH] = i_removal_event;
        gs_set[`PCS_GS_PLUGIN] = i_attach_event;
        gs_clr = gs_read ? `PCS_GS_COR_MASK : 8'h00;
        gs_clr[`PCS_GS_CLAMP] = ~i_clamp_active;
        if (i_budget_reset_control || !i_budget_enable_control)
            gs_clr[`PCS_GS_BUDGET] = 1'b1;
    end

    // Passthrough is blocked in the removal cycle so a re-attach cannot revive it
    assign pt_set = i_passthrough_mode & st_r.pt_armed & pwr_eff & ~i_removal_event;
    assign gl_set = {1'b0, i_accept_legacy & {7{i_dce_active}}};
    assign gl_clr = {8{prof_clr}};
    assign accept_any = i_accept_custom | i_accept_dcp | i_accept_chp | pt_set | (|gl_set);
    assign others_held = (|gp_q[`PCS_GP_USER:`PCS_GP_PT]) | (|gl_q);
    assign nohs_set = i_profile_handshake_missing_flag & i_dce_active & ~accept_any & ~others_held;

    // Profile status primary flags
    always_comb
    begin
        gp_set = 8'h00;
        gp_set[`PCS_GP_NOHS] = nohs_set;
        gp_set[`PCS_GP_UVLO] = i_vs_below_uvlo;
        gp_set[`PCS_GP_USER] = i_accept_custom & i_dce_active;
        gp_set[`PCS_GP_DCP] = i_accept_dcp;
        gp_set[`PCS_GP_CHP] = i_accept_chp;
        gp_set[`PCS_GP_PT] = pt_set;
        gp_clr = 8'h00;
        gp_clr[`PCS_GP_NOHS] = i_profile_applied | accept_any;
        gp_clr[`PCS_GP_UVLO] = ~i_vs_below_uvlo;
        gp_clr[`PCS_GP_USER:`PCS_GP_PT] = {4{prof_clr}};
        gp_clr[6:5] = 2'h3;
    end

    pcs_sticky_byte u_gs_cell (
        .i_core_clk(i_core_clk),
        .i_reset_n(i_reset_n),
        .i_set(gs_set),
        .i_clr(gs_clr),
        .o_q(gs_q)
    );

    pcs_sticky_byte u_gp_cell (
        .i_core_clk(i_core_clk),
        .i_reset_n(i_reset_n),
        .i_set(gp_set),
        .i_clr(gp_clr),
        .o_q(gp_q)
    );

    pcs_sticky_byte u_gl_cell (
        .i_core_clk(i_core_clk),
        .i_reset_n(i_reset_n),
        .i_set(gl_set),
        .i_clr(gl_clr),
        .o_q(gl_q)
    );

    // Next state of pins, read data and housekeeping
    always_comb
    begin
        st_nxt = st_r;
        // Strap is caught once after release, never inside reset
        if (!st_r.strap_done)
        begin
            st_nxt.strap = i_sel_strap;
            st_nxt.strap_done = 1'b1;
        end
        st_nxt.mode_prev = mode_now;
        // A mode change re-arms passthrough, a removal disarms it
        if (mode_chg)
            st_nxt.pt_armed = 1'b1;
        else if (i_removal_event)
            st_nxt.pt_armed = 1'b0;
        // Attach pin follows plug-in and detach events only
        if (i_attach_event)
            st_nxt.attach = 1'b1;
        else if (i_removal_event)
            st_nxt.attach = 1'b0;
        // Profile flags stay out of the alert on purpose
        st_nxt.alert = (gs_q[`PCS_GS_BUDGET]
                        && (i_budget_behaviour_select == `PCS_BEH_INTERRUPT))
                       || (i_alert_link
                           && (gs_q[`PCS_GS_THERMAL] || gs_q[`PCS_GS_TRICKLE]));
        {st_nxt.hsw, st_nxt.trip} = path_select(gp_q, gl_q);
        st_nxt.rd_ack = i_rd_en;
        if (i_rd_en)
        begin
            unique case (i_rd_addr)
                `PCS_GS_OFF: st_nxt.rd_data = gs_q & `PCS_GS_MASK;
                `PCS_GP_OFF: st_nxt.rd_data = gp_q;
                `PCS_GL_OFF: st_nxt.rd_data = gl_q;
                `PCS_PIN_OFF: st_nxt.rd_data = {1'b0, pwr_eff, mode_b_eff, mode_a_eff, emu_eff,
                                                st_r.strap, wake_state(i_power_state_code)};
                default: st_nxt.rd_data = `PCS_UNMAPPED_DATA;
            endcase
        end
    end

    // State register
    always_ff @(posedge i_core_clk)
    begin
        if (!i_reset_n)
        begin
            st_r <= '0;
            st_r.pt_armed <= `PCS_PT_ARMED_RST;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    // Outputs come straight from the state register
    assign o_rd_data = st_r.rd_data;
    assign o_rd_ack = st_r.rd_ack;
    assign o_fault_alert = st_r.alert;
    assign o_attach_out = st_r.attach;
    assign o_data_switch_closed = st_r.hsw;
    assign o_trip_limit = st_r.trip;

    // Named steps reused by the checks
    sequence s_gs_read;
        i_rd_en && (i_rd_addr == `PCS_GS_OFF);
    endsequence

    sequence s_pin_answer;
        o_rd_ack && ($past(i_rd_addr) == `PCS_PIN_OFF);
    endsequence

    sequence s_quiet_removal;
        i_removal_event && !accept_any && !i_accept_custom;
    endsequence

    a_budget_alert: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
        (gs_q[`PCS_GS_BUDGET] && i_budget_behaviour_select == `PCS_BEH_INTERRUPT)
        |=> o_fault_alert)
        else $error("budget flag did not raise alert");

    a_budget_clear: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
        (i_budget_reset_control && !i_budget_hit) |=> !gs_q[`PCS_GS_BUDGET])
        else $error("budget flag survived budget reset");

    a_link_gate: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
        (!i_alert_link && !(gs_q[`PCS_GS_BUDGET]
            && i_budget_behaviour_select == `PCS_BEH_INTERRUPT)) |=> !o_fault_alert)
        else $error("alert raised without a linked cause");

    a_attach_pin: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
        i_attach_event |=> o_attach_out && gs_q[`PCS_GS_PLUGIN])
        else $error("attach event not shown on pin and flag");

    a_detach_pin: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
        (i_removal_event && !i_attach_event)
        |=> !o_attach_out ##1 (!o_attach_out || $past(i_attach_event)))
        else $error("removal did not release attach pin");

    a_read_keeps: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
        s_gs_read and i_thermal_event |=> gs_q[`PCS_GS_THERMAL])
        else $error("thermal event lost to clearing read");

    a_read_clears: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
        s_gs_read and !i_thermal_event and !i_low_current_event
        |=> !gs_q[`PCS_GS_THERMAL] && !gs_q[`PCS_GS_TRICKLE])
        else $error("indicator flags not cleared by read");

    a_nohs_alone: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
        gp_q[`PCS_GP_NOHS] |-> (gp_q[`PCS_GP_USER:`PCS_GP_PT] == 4'h0) && (gl_q == 8'h00))
        else $error("no-handshake flag set beside another profile flag");

    a_removal_clear: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
        s_quiet_removal |=> (gl_q == 8'h00) && (gp_q[`PCS_GP_USER:`PCS_GP_PT] == 4'h0))
        else $error("profile flags survived removal");

    a_uvlo_follow: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
        ##1 (gp_q[`PCS_GP_UVLO] == $past(i_vs_below_uvlo)))
        else $error("undervoltage flag does not follow source");

    a_chp_path: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
        gp_q[`PCS_GP_CHP] |=> o_data_switch_closed && o_trip_limit)
        else $error("host-port profile without closed switch and trip limit");

    a_pin_state: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
        s_pin_answer |-> (o_rd_data[1:0] != `PCS_PS_SLEEP)
            && (o_rd_data[`PCS_PIN_MODE_A] == $past(mode_a_eff)))
        else $error("pin status answer wrong");

    a_budget_disable: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
        (!i_budget_enable_control && !i_budget_hit) |=> !gs_q[`PCS_GS_BUDGET])
        else $error("budget flag survived budget disable");

    a_custom_gate: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
        (i_accept_custom && !i_dce_active && !gp_q[`PCS_GP_USER]) |=> !gp_q[`PCS_GP_USER])
        else $error("custom profile flag set outside the dedicated cycle");

    a_dcp_path: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
        (gp_q[`PCS_GP_DCP] && !gp_q[`PCS_GP_CHP] && !gp_q[`PCS_GP_PT])
        |=> (o_data_switch_closed == $past(i_data_switch_in_dedicated)) && !o_trip_limit)
        else $error("dedicated profile without its switch and constant limit");

    a_pt_blocked: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
        !st_r.pt_armed |=> !gp_q[`PCS_GP_PT])
        else $error("passthrough flag set while disarmed");
endmodule

// ---- core/pcs_sticky_byte.sv ----
// Eight sticky flags where a set always beats a clear in the same cycle
`timescale 1ns/10ps
`include "pcs_defines.svh"
module pcs_sticky_byte (
    input wire logic i_core_clk,
    input wire logic i_reset_n,
    input wire pcs_pkg::pcs_byte_t i_set,
    input wire pcs_pkg::pcs_byte_t i_clr,
    output pcs_pkg::pcs_byte_t o_q
);
    import pcs_pkg::*;

    pcs_cell_s st_r;
    pcs_cell_s st_nxt;

    // Set term first so no event is lost to a read
    always_comb
    begin
        st_nxt = st_r;
        st_nxt.q = i_set | (st_r.q & ~i_clr);
    end

    // State register
    always_ff @(posedge i_core_clk)
    begin
        if (!i_reset_n)
            st_r <= '{q: `PCS_FLAGS_RST};
        else
            st_r <= st_nxt;
    end

    assign o_q = st_r.q;

    a_set_wins: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
        (|i_set) |=> ((o_q & $past(i_set)) == $past(i_set)))
        else $error("set event lost against clear");
endmodule

// ---- testbench/pcs_host_model.sv ----
// Host model that reads the status registers one byte at a time
`timescale 1ns/10ps
module pcs_host_model (
    input wire logic i_core_clk,
    input wire logic i_rd_ack,
    input wire pcs_pkg::pcs_byte_t i_rd_data,
    output logic o_rd_en,
    output pcs_pkg::pcs_byte_t o_rd_addr
);
    import pcs_pkg::*;
    // Idle offset is scrambled so a stale address never looks valid
    initial
    begin
        o_rd_en = 1'b0;
        o_rd_addr = 8'hA5;
    end
    // Strobe for one edge, take data with the ack, then release
    task automatic read(input pcs_byte_t a, output pcs_byte_t d, output logic ok);
        o_rd_en = 1'b1;
        o_rd_addr = a;
        @(negedge i_core_clk);
        ok = i_rd_ack === 1'b1;
        d = i_rd_data;
        o_rd_en = 1'b0;
        o_rd_addr = ~a;
        @(negedge i_core_clk);
        ok = ok && i_rd_ack === 1'b0;
    endtask
endmodule

// ---- testbench/tb_port_charger_status_regs.sv ----
// Self-checking bench for the port charger status register group
`timescale 1ns/10ps
`include "pcs_defines.svh"
module tb_port_charger_status_regs;
    import pcs_pkg::*;
    logic clk, rst_n, rd_en, hit, clamp, therm, lowc, detach_flag, plugin_flag, uv, dce, appl, nohs;
    logic a_user_profile_flag, a_dcp, a_chp, ptm, brst, ben, link, c_hsw, c_trip, hsw_d, strap;
    logic pw_p, pw_s, ma_p, ma_s, mb_p, mb_s, em_p, em_s, ack, alert, att_o, sw, trip;
    logic [6:0] a_leg;
    logic [1:0] beh;
    pcs_pstate_t ps;
    pcs_byte_t addr, data;
    int fail_count, comparisons;
    // Core clock, 100 ns period
    always #50 clk = ~clk;
    pcs_status_regs u_dut (
        .i_core_clk(clk), .i_reset_n(rst_n), .i_rd_en(rd_en), .i_rd_addr(addr),
        .i_budget_hit(hit), .i_clamp_active(clamp), .i_thermal_event(therm),
        .i_low_current_event(lowc), .i_removal_event(detach_flag), .i_attach_event(plugin_flag),
        .i_vs_below_uvlo(uv), .i_dce_active(dce), .i_profile_applied(appl),
        .i_profile_handshake_missing_flag(nohs), .i_accept_custom(a_user_profile_flag), .i_accept_dcp(a_dcp),
        .i_accept_chp(a_chp), .i_accept_legacy(a_leg), .i_passthrough_mode(ptm),
        .i_budget_reset_control(brst), .i_budget_enable_control(ben),
        .i_budget_behaviour_select(beh), .i_alert_link(link), .i_custom_hsw_closed(c_hsw),
        .i_custom_trip_limit(c_trip), .i_data_switch_in_dedicated(hsw_d),
        .i_port_power_enable_pin(pw_p), .i_port_power_enable_set(pw_s),
        .i_mode_input_a_pin(ma_p), .i_mode_input_a_set(ma_s), .i_mode_input_b_pin(mb_p),
        .i_mode_input_b_set(mb_s), .i_emulation_enable_pin(em_p),
        .i_emulation_enable_set(em_s), .i_sel_strap(strap), .i_power_state_code(ps),
        .o_rd_data(data), .o_rd_ack(ack), .o_fault_alert(alert), .o_attach_out(att_o),
        .o_data_switch_closed(sw), .o_trip_limit(trip)
    );
    pcs_host_model u_host (
        .i_core_clk(clk), .i_rd_ack(ack), .i_rd_data(data), .o_rd_en(rd_en),
        .o_rd_addr(addr)
    );
    // Shared compare, counts every call
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            fail_count++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic pulse(ref logic s);
        s = 1'b1;
        step(1);
        s = 1'b0;
    endtask
    // Alert, attach, switch and limit in one nibble
    task automatic outs(input logic [3:0] e);
        chk({4'h0, alert, att_o, sw, trip}, {4'h0, e});
    endtask
    // One read; the ack pulse is checked on every read
    task automatic rd(input pcs_byte_t a, input pcs_byte_t e);
        pcs_byte_t d;
        logic ok;
        u_host.read(a, d, ok);
        chk({7'h00, ok}, 8'h01);
        chk(d, e);
    endtask
    task automatic do_reset(input logic s);
        strap = s;
        rst_n = 1'b0;
        step(12);
        rst_n = 1'b1;
        step(2);
    endtask
    // Attach and removal, then an attach landing on the clearing read
    task automatic t_attach();
        pulse(plugin_flag);
        outs(4'h4);
        rd(`PCS_GS_OFF, 8'h01);
        rd(`PCS_GS_OFF, 8'h00);
        pulse(detach_flag);
        step(1);
        outs(4'h0);
        rd(`PCS_GS_OFF, 8'h02);
        rd(`PCS_GS_OFF, 8'h00);
        fork
            rd(`PCS_GS_OFF, 8'h00);
            pulse(plugin_flag);
        join
        rd(`PCS_GS_OFF, 8'h01);
    endtask
    // Thermal and trickle flags, with and without the alert link
    task automatic t_ind();
        for (int l = 0; l < 2; l++)
        begin
            for (int b = 2; b < 4; b++)
            begin
                link = l[0];
                lowc = (b == 2);
                therm = (b == 3);
                step(1);
                {lowc, therm} = 2'b00;
                step(1);
                chk({7'h00, alert}, {7'h00, l[0]});
                rd(`PCS_GS_OFF, 8'h01 << b);
                chk({7'h00, alert}, 8'h00);
                rd(`PCS_GS_OFF, 8'h00);
            end
        end
        link = 1'b0;
    endtask
    // Budget flag under every behaviour code, then its automatic clears
    task automatic t_budget();
        ben = 1'b1;
        for (int bh = 0; bh < 4; bh++)
        begin
            beh = bh[1:0];
            pulse(hit);
            step(1);
            chk({7'h00, alert}, {7'h00, bh == 0});
            rd(`PCS_GS_OFF, 8'h80);
            rd(`PCS_GS_OFF, 8'h00);
        end
        // First pass clears by budget reset alone, second by budget disable alone
        for (int k = 0; k < 2; k++)
        begin
            pulse(hit);
            brst = (k == 0);
            ben = (k == 0);
            step(1);
            {brst, ben} = 2'b01;
            rd(`PCS_GS_OFF, 8'h00);
        end
    endtask
    // Live clamp and undervoltage levels survive reads
    task automatic t_live();
        {clamp, uv} = 2'b11;
        step(1);
        rd(`PCS_GS_OFF, 8'h10);
        rd(`PCS_GS_OFF, 8'h10);
        rd(`PCS_GP_OFF, 8'h10);
        {clamp, uv} = 2'b00;
        step(1);
        rd(`PCS_GS_OFF, 8'h00);
        rd(`PCS_GP_OFF, 8'h00);
    endtask
    // Accept one profile, check flags and switch, then clear by cause c
    task automatic acc(input int k, input pcs_byte_t a, input pcs_byte_t e,
                       input logic [1:0] st, input int c);
        logic keep;
        keep = att_o;
        a_user_profile_flag = (k == 0);
        a_dcp = (k == 1);
        a_chp = (k == 2);
        a_leg = (k > 2) ? 7'(1 << (k - 3)) : 7'h00;
        step(1);
        {a_user_profile_flag, a_dcp, a_chp, a_leg} = '0;
        step(2);
        outs({1'b0, keep, st});
        rd(a, e);
        pw_p = (c != 1);
        em_s = em_s ^ (c == 2);
        detach_flag = (c == 0);
        step(1);
        {pw_p, detach_flag} = 2'b10;
        step(1);
        rd(a, 8'h00);
    endtask
    task automatic t_prof();
        {dce, c_hsw, c_trip, hsw_d} = 4'hF;
        acc(0, `PCS_GP_OFF, 8'h08, 2'b11, 0);
        acc(1, `PCS_GP_OFF, 8'h04, 2'b10, 1);
        acc(2, `PCS_GP_OFF, 8'h02, 2'b11, 2);
        // Custom switch setting open, so the switch must follow it
        c_hsw = 1'b0;
        acc(0, `PCS_GP_OFF, 8'h08, 2'b01, 1);
        for (int k = 0; k < 7; k++)
        begin
            hsw_d = k[0];
            c_trip = k[1];
            acc(k + 3, `PCS_GL_OFF, 8'(1 << k), {k[0], k[1]}, k % 3);
        end
        dce = 1'b0;
        acc(0, `PCS_GP_OFF, 8'h00, {1'b0, c_trip}, 0);
    endtask
    // Missing handshake flag set, cleared and blocked by other flags
    task automatic t_nohs();
        dce = 1'b1;
        pulse(nohs);
        step(1);
        rd(`PCS_GP_OFF, 8'h80);
        pulse(appl);
        step(1);
        rd(`PCS_GP_OFF, 8'h00);
        a_dcp = 1'b1;
        pulse(nohs);
        a_dcp = 1'b0;
        step(1);
        rd(`PCS_GP_OFF, 8'h04);
        pulse(nohs);
        step(1);
        rd(`PCS_GP_OFF, 8'h04);
        pulse(detach_flag);
        dce = 1'b0;
        pulse(nohs);
        step(1);
        rd(`PCS_GP_OFF, 8'h00);
    endtask
    // Passthrough flag, lost after removal and attach, rearmed by mode toggle
    task automatic t_pt();
        c_trip = 1'b0;
        for (int n = 0; n < 2; n++)
        begin
            pulse(ma_s);
            ptm = 1'b1;
            step(4);
            rd(`PCS_GP_OFF, 8'h01);
            // Attach pin is down in the first pass and up in the second, from the first pass's re-attach
            outs({1'b0, n[0], 2'b11});
            pulse(detach_flag);
            pulse(plugin_flag);
            step(2);
            rd(`PCS_GP_OFF, 8'h00);
        end
        ptm = 1'b0;
    endtask
    // Pin mirrors, strap and power state under both strap values
    task automatic t_pins();
        logic [3:0] p, s;
        logic [7:0] e;
        for (int st = 0; st < 2; st++)
        begin
            do_reset(st[0]);
            for (int i = 0; i < 16; i++)
            begin
                p = i[3:0];
                s = 4'(i * 3);
                {pw_p, mb_p, ma_p, em_p} = p;
                {pw_s, mb_s, ma_s, em_s} = s;
                ps = i[1:0];
                step(1);
                e = {1'b0, (st[0] ? p[3] : ~p[3]) | s[3], p[2:0] | s[2:0], st[0], ps};
                e[1:0] = (ps == 2'b00) ? 2'b01 : ps;
                rd(`PCS_PIN_OFF, e);
            end
        end
    endtask
    task automatic end_of_test();
        $display("Comparisons %0d, mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // Main sequence; power enable pin starts active for the high strap
    initial
    begin
        {clk, rst_n, hit, clamp, therm, lowc, detach_flag, plugin_flag, uv, dce, appl, nohs} = '0;
        {a_user_profile_flag, a_dcp, a_chp, a_leg, ptm, brst, ben, link, c_hsw, c_trip, hsw_d} = '0;
        {beh, ps, pw_s, ma_p, ma_s, mb_p, mb_s, em_p, em_s} = '0;
        {pw_p, strap} = 2'b11;
        do_reset(1'b1);
        outs(4'h0);
        rd(`PCS_GS_OFF, 8'h00);
        rd(`PCS_GP_OFF, 8'h00);
        rd(`PCS_GL_OFF, 8'h00);
        rd(8'h20, 8'h00);
        t_attach();
        t_ind();
        t_budget();
        t_live();
        t_prof();
        t_nohs();
        t_pt();
        t_pins();
        end_of_test();
    end
    // Watchdog, about 26 times the expected run
    initial
    begin
        #1000000;
        fail_count++;
        end_of_test();
    end
endmodule
